// File: src/eocm_regs.vh
`ifndef EOCM_REGS_VH
`define EOCM_REGS_VH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EOCM_OSC_ADDR 8'hb1
`define EOCM_MUL_ADDR 8'hb9
`define EOCM_OSC_RESET 8'h00
`define EOCM_MUL_RESET 8'h00
`define EOCM_OSC_VALID_BIT 7
`define EOCM_OSC_MODE_HI 6
`define EOCM_OSC_MODE_LO 4
`define EOCM_OSC_BAND_HI 2
`define EOCM_OSC_BAND_LO 0
`define EOCM_MUL_EN_BIT 7
`define EOCM_MUL_INIT_BIT 6
`define EOCM_MUL_LOCK_BIT 5
`define EOCM_MUL_SEL_HI 1
`define EOCM_MUL_SEL_LO 0
// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define EOCM_MODE_CMOS 3'h2
`define EOCM_MODE_CMOS_DIV2 3'h3
`define EOCM_MODE_RC 3'h4
`define EOCM_MODE_CAP 3'h5
`define EOCM_MODE_XTAL 3'h6
`define EOCM_MODE_XTAL_DIV2 3'h7
`define EOCM_MSEL_INT 2'h0
`define EOCM_MSEL_EXT 2'h1
`define EOCM_MSEL_EXT_DIV2 2'h2
`define EOCM_SCLK_EXT 2'h1
`define EOCM_SCLK_MUL 2'h2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EOCM_CLK_MHZ 25
`define EOCM_SETTLE_US 1000
`define EOCM_SETTLE_CYC (`EOCM_SETTLE_US * `EOCM_CLK_MHZ)
`define EOCM_LOCK_CYC 16'h40
`endif

// File: src/eocm_sync.v
`timescale 1ns/1ps
// Two-flop level synchroniser with edge detect on the second stage only
module eocm_sync (
  clk,
  reset_n,
  ce,
  din,
  dout_ff,
  edge_ff
);
  input wire clk;
  input wire reset_n;
  input wire ce;
  input wire din;
  output reg dout_ff;
  output reg edge_ff;
  reg meta_ff;
  reg prev_ff;
  // Edge costs one more cycle, but the metastable stage has one reader only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      dout_ff <= 1'b0;
      prev_ff <= 1'b0;
      edge_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= din;
      dout_ff <= meta_ff;
      prev_ff <= dout_ff;
      edge_ff <= dout_ff & ~prev_ff;
    end
  end
endmodule // eocm_sync

// File: src/eocm_top.v
`timescale 1ns/1ps
`include "eocm_regs.vh"
module eocm_top #(
  parameter SETTLE_CYC = `EOCM_SETTLE_CYC
) (
  clk,
  reset_n,
  ce,
  sfr_addr,
  sfr_wdata,
  sfr_wr,
  sfr_rd,
  sfr_rdata_ff,
  ext_osc_in,
  int_osc_in,
  xtal_amp_ok,
  mul_lock_in,
  system_clock_signal_source_select,
  ext_osc_en_ff,
  ext_osc_mode_ff,
  ext_freq_band_ff,
  timer_tick_ff,
  mul_enable_ff,
  mul_init_pulse_ff,
  mul_input_select_ff,
  mul_ref_clk_ff,
  system_clock_signal_mul_half_ff,
  system_clock_signal_ext_sel_ff
);
  input wire clk;
  input wire reset_n;
  input wire ce;
  input wire [7:0] sfr_addr;
  input wire [7:0] sfr_wdata;
  input wire sfr_wr;
  input wire sfr_rd;
  output reg [7:0] sfr_rdata_ff;
  input wire ext_osc_in;
  input wire int_osc_in;
  input wire xtal_amp_ok;
  input wire mul_lock_in;
  input wire [1:0] system_clock_signal_source_select;
  output reg ext_osc_en_ff;
  output reg [2:0] ext_osc_mode_ff;
  output reg [2:0] ext_freq_band_ff;
  output reg timer_tick_ff;
  output reg mul_enable_ff;
  output reg mul_init_pulse_ff;
  output reg [1:0] mul_input_select_ff;
  output reg mul_ref_clk_ff;
  output reg system_clock_signal_mul_half_ff;
  output reg system_clock_signal_ext_sel_ff;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_xtal;
    input [2:0] m;
    begin
      is_xtal = (m == `EOCM_MODE_XTAL) || (m == `EOCM_MODE_XTAL_DIV2);
    end
  endfunction

  function has_div2;
    input [2:0] m;
    begin
      has_div2 = (m == `EOCM_MODE_CMOS_DIV2) || (m == `EOCM_MODE_XTAL_DIV2);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire ext_sync;
  wire ext_rise;
  wire int_sync;
  reg amp_m_ff;
  reg amp_s_ff;
  reg lock_m_ff;
  reg lock_s_ff;

  eocm_sync u_ext (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .din(ext_osc_in),
    .dout_ff(ext_sync),
    .edge_ff(ext_rise)
  );

  eocm_sync u_int (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .din(int_osc_in),
    .dout_ff(int_sync),
    .edge_ff()
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_m_ff <= 1'b0;
      amp_s_ff <= 1'b0;
      lock_m_ff <= 1'b0;
      lock_s_ff <= 1'b0;
    end else if (ce) begin
      amp_m_ff <= xtal_amp_ok;
      amp_s_ff <= amp_m_ff;
      lock_m_ff <= mul_lock_in;
      lock_s_ff <= lock_m_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg valid_ff;
  reg [31:0] settle_ff;
  reg div2_ff;
  reg [2:0] div8_ff;
  reg locked_ff;
  reg [15:0] lock_cnt_ff;
  reg mhalf_ff;
  wire osc_wr = sfr_wr && (sfr_addr == `EOCM_OSC_ADDR);
  wire mul_wr = sfr_wr && (sfr_addr == `EOCM_MUL_ADDR);
  wire ext_on = ext_osc_mode_ff[2] | ext_osc_mode_ff[1];
  wire ext_tick = ext_on && ext_rise && (!has_div2(ext_osc_mode_ff) || div2_ff);
  wire nxt_init = mul_wr && mul_enable_ff && sfr_wdata[`EOCM_MUL_INIT_BIT];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_osc_mode_ff <= 3'h0;
      ext_freq_band_ff <= 3'h0;
      ext_osc_en_ff <= 1'b0;
      mul_enable_ff <= 1'b0;
      mul_input_select_ff <= 2'h0;
      mul_init_pulse_ff <= 1'b0;
    end else if (ce) begin
      if (osc_wr) begin
        ext_osc_mode_ff <= sfr_wdata[`EOCM_OSC_MODE_HI:`EOCM_OSC_MODE_LO];
        ext_freq_band_ff <= sfr_wdata[`EOCM_OSC_BAND_HI:`EOCM_OSC_BAND_LO];
        // Enable moves with the mode field, never a cycle behind it
        ext_osc_en_ff <= sfr_wdata[`EOCM_OSC_MODE_HI] | sfr_wdata[`EOCM_OSC_MODE_HI - 1];
      end
      if (mul_wr) begin
        mul_enable_ff <= sfr_wdata[`EOCM_MUL_EN_BIT];
        mul_input_select_ff <= sfr_wdata[`EOCM_MUL_SEL_HI:`EOCM_MUL_SEL_LO];
      end
      mul_init_pulse_ff <= nxt_init;
    end
  end

  // ----------------------------------------------------------------
  // Crystal settling and valid flag
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_ff <= 32'h0;
      valid_ff <= 1'b0;
    end else if (ce) begin
      if (!is_xtal(ext_osc_mode_ff) || !amp_s_ff) begin
        settle_ff <= 32'h0;
        valid_ff <= 1'b0;
      end else if (settle_ff >= SETTLE_CYC) begin
        valid_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Divide by eight tick for timers and counter array
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div2_ff <= 1'b0;
      div8_ff <= 3'h0;
      timer_tick_ff <= 1'b0;
    end else if (ce) begin
      if (ext_on && ext_rise)
        div2_ff <= ~div2_ff;
      if (ext_tick)
        div8_ff <= div8_ff + 3'h1;
      timer_tick_ff <= ext_tick && (div8_ff == 3'h7);
    end
  end

  // ----------------------------------------------------------------
  // Multiplier lock and reference
  // ----------------------------------------------------------------
  // Lock needs both the analog flag and a minimum count after init
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      locked_ff <= 1'b0;
      lock_cnt_ff <= 16'h0;
      mul_ref_clk_ff <= 1'b0;
      mhalf_ff <= 1'b0;
      system_clock_signal_mul_half_ff <= 1'b0;
      system_clock_signal_ext_sel_ff <= 1'b0;
    end else if (ce) begin
      if (!mul_enable_ff || mul_init_pulse_ff) begin
        lock_cnt_ff <= mul_init_pulse_ff ? 16'h1 : 16'h0;
        locked_ff <= 1'b0;
      end else if (lock_cnt_ff != 16'h0) begin
        if (lock_cnt_ff < `EOCM_LOCK_CYC)
          lock_cnt_ff <= lock_cnt_ff + 16'h1;
        locked_ff <= (lock_cnt_ff >= `EOCM_LOCK_CYC) && lock_s_ff;
      end
      case (mul_input_select_ff)
        `EOCM_MSEL_INT: mul_ref_clk_ff <= int_sync;
        `EOCM_MSEL_EXT: mul_ref_clk_ff <= ext_sync;
        `EOCM_MSEL_EXT_DIV2: mul_ref_clk_ff <= div2_ff;
        default: mul_ref_clk_ff <= 1'b0;
      endcase
      // Stand-in for the x4 output halved; the real loop is analog
      mhalf_ff <= locked_ff ? ~mhalf_ff : 1'b0;
      system_clock_signal_mul_half_ff <= mhalf_ff && (system_clock_signal_source_select == `EOCM_SCLK_MUL);
      system_clock_signal_ext_sel_ff <= (system_clock_signal_source_select == `EOCM_SCLK_EXT);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_rdata_ff <= 8'h00;
    end else if (ce) begin
      if (sfr_rd && sfr_addr == `EOCM_OSC_ADDR) begin
        // Flag is masked at once when the mode leaves crystal
        sfr_rdata_ff <= {valid_ff & is_xtal(ext_osc_mode_ff), ext_osc_mode_ff, 1'b0,
          ext_freq_band_ff};
      end else if (sfr_rd && sfr_addr == `EOCM_MUL_ADDR) begin
        sfr_rdata_ff <= {mul_enable_ff, 1'b0, locked_ff, 3'h0, mul_input_select_ff};
      end else begin
        sfr_rdata_ff <= 8'h00;
      end
    end
  end
endmodule // eocm_top

// File: test/eocm_osc_model.sv
`timescale 1ns/1ps
module eocm_osc_model #(
  parameter HALF_NS = 80,
  parameter AMP_NS = 400,
  parameter LOCK_CYC = 90
) (
  input logic clk,
  input logic ext_osc_en_ff,
  input logic [2:0] ext_osc_mode_ff,
  input logic mul_init_pulse_ff,
  output logic ext_osc_in = 1'b0,
  output logic int_osc_in = 1'b0,
  output logic xtal_amp_ok = 1'b0,
  output logic mul_lock_in = 1'b0
);
  int cnt = 0;
  // Slower than clk on purpose; network idles low when undriven
  always #(HALF_NS) ext_osc_in = ext_osc_en_ff ? !ext_osc_in : 1'b0;
  always #42 int_osc_in = !int_osc_in;
  // Amplitude needs time to build after crystal mode is chosen
  always @(ext_osc_mode_ff) begin
    xtal_amp_ok = 1'b0;
    if (ext_osc_mode_ff[2:1] == 2'h3) xtal_amp_ok <= #(AMP_NS) 1'b1;
  end
  always @(posedge clk) begin
    if (mul_init_pulse_ff) begin
      cnt <= LOCK_CYC;
      mul_lock_in <= 1'b0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) mul_lock_in <= 1'b1;
    end
  end
endmodule // eocm_osc_model

// File: test/eocm_top_sva.sv
`timescale 1ns/1ps
module eocm_top_sva #(parameter SETTLE_CYC = 20) (
  input logic clk,
  input logic reset_n,
  input logic ce,
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_wdata,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_rdata_ff,
  input logic ext_osc_en_ff,
  input logic [2:0] ext_osc_mode_ff,
  input logic [2:0] ext_freq_band_ff,
  input logic timer_tick_ff,
  input logic mul_enable_ff,
  input logic mul_init_pulse_ff,
  input logic [1:0] mul_input_select_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reads with a write in the same cycle are left out: field may move
  wire rd_o = ce && sfr_rd && !sfr_wr && sfr_addr == 8'hb1;
  wire rd_m = ce && sfr_rd && !sfr_wr && sfr_addr == 8'hb9;
  wire wr_m = ce && sfr_wr && sfr_addr == 8'hb9;
  wire init_ok = wr_m && sfr_wdata[6] && mul_enable_ff;
  property p_osc_rd; rd_o |=> sfr_rdata_ff[6:0] == {ext_osc_mode_ff, 1'b0, ext_freq_band_ff};
  endproperty
  a_osc_rd: assert property (p_osc_rd) else $error("osc read field mismatch");
  property p_mul_rd; rd_m |=> sfr_rdata_ff[4:0] == {3'h0, mul_input_select_ff}; endproperty
  a_mul_rd: assert property (p_mul_rd) else $error("mul read field mismatch");
  property p_valid_off; rd_o && ext_osc_mode_ff[2:1] != 2'h3 |=> !sfr_rdata_ff[7]; endproperty
  a_valid_off: assert property (p_valid_off) else $error("valid set outside crystal");
  property p_en_rd; rd_m |=> sfr_rdata_ff[7] == mul_enable_ff; endproperty
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  property p_en_wr; wr_m |=> mul_enable_ff == $past(sfr_wdata[7]); endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable not written");
  property p_init;
    init_ok |=> mul_init_pulse_ff ##1 (!mul_init_pulse_ff || $past(init_ok));
  endproperty
  a_init: assert property (p_init) else $error("init pulse missing");
  property p_init_cause; mul_init_pulse_ff |-> $past(init_ok); endproperty
  a_init_cause: assert property (p_init_cause) else $error("init without cause");
  property p_tick; timer_tick_ff |=> !timer_tick_ff [*8]; endproperty
  a_tick: assert property (p_tick) else $error("ticks too close");
  property p_osc_en; ext_osc_en_ff == (ext_osc_mode_ff[2:1] != 2'h0); endproperty
  a_osc_en: assert property (p_osc_en) else $error("osc enable vs mode");
  c_init: cover property (init_ok);
  c_tick: cover property (timer_tick_ff);
  c_valid: cover property (rd_o ##1 sfr_rdata_ff[7]);
endmodule // eocm_top_sva

// File: test/tb_eocm_top.sv
`timescale 1ns/1ps
module tb_eocm_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [1:0] system_clock_signal_source_select = 2'h0;
  wire [7:0] sfr_rdata_ff;
  wire ext_osc_in, int_osc_in, xtal_amp_ok, mul_lock_in, ext_osc_en_ff, timer_tick_ff;
  wire mul_enable_ff, mul_init_pulse_ff;
  wire mul_ref_clk_ff, system_clock_signal_mul_half_ff, system_clock_signal_ext_sel_ff;
  wire [2:0] ext_osc_mode_ff, ext_freq_band_ff;
  wire [1:0] mul_input_select_ff;
  int failures = 0;
  int checked = 0;
  int n;
  logic [7:0] d;
  always #20 clk = !clk;
  eocm_top #(.SETTLE_CYC(20)) eocm_top_inst (.clk, .reset_n, .ce(1'b1), .sfr_addr, .sfr_wdata,
    .sfr_wr, .sfr_rd, .sfr_rdata_ff, .ext_osc_in, .int_osc_in, .xtal_amp_ok, .mul_lock_in,
    .system_clock_signal_source_select, .ext_osc_en_ff, .ext_osc_mode_ff, .ext_freq_band_ff, .timer_tick_ff,
    .mul_enable_ff, .mul_init_pulse_ff, .mul_input_select_ff, .mul_ref_clk_ff,
    .system_clock_signal_mul_half_ff, .system_clock_signal_ext_sel_ff);
  eocm_osc_model eocm_osc_model_inst (.clk, .ext_osc_en_ff, .ext_osc_mode_ff,
    .mul_init_pulse_ff, .ext_osc_in, .int_osc_in, .xtal_amp_ok, .mul_lock_in);
  task wrap_up;
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    v = sfr_rdata_ff;
  endtask
  task t_regs;
    rd(8'hb1, d);
    chk(d, 8'h00);
    rd(8'hb9, d);
    chk(d, 8'h00);
    wr(8'hb1, 8'hff);
    rd(8'hb1, d);
    chk(d, 8'h77);
    rd(8'hb2, d);
    chk(d, 8'h00);
    for (int m = 0; m < 8; m++) begin
      wr(8'hb1, {1'b0, m[2:0], 4'h5});
      @(posedge clk);
      #1;
      chk({7'h0, ext_osc_en_ff}, {7'h0, m[2:1] != 2'h0});
      chk({5'h0, ext_osc_mode_ff}, {5'h0, m[2:0]});
      chk({5'h0, ext_freq_band_ff}, 8'h05);
    end
    wr(8'hb1, 8'h42);
    rd(8'hb1, d);
    chk(d, 8'h42);
    wr(8'hb1, 8'h53);
    rd(8'hb1, d);
    chk(d, 8'h53);
  endtask
  task t_xtal;
    wr(8'hb1, 8'h67);
    n = 0;
    d = 8'h00;
    while (!d[7] && n < 200) begin
      rd(8'hb1, d);
      n++;
    end
    chk(d, 8'he7);
    chk({7'h0, n >= 10}, 8'h01);
    if (n == 200) wrap_up();
    system_clock_signal_source_select = 2'h1;
    repeat (2) @(posedge clk);
    #1 chk({7'h0, system_clock_signal_ext_sel_ff}, 8'h01);
  endtask
  task t_tick(input logic [7:0] v, input int lo);
    wr(8'hb1, v);
    repeat (40) @(posedge clk);
    n = 0;
    repeat (640) begin
      @(posedge clk);
      #1 n += timer_tick_ff;
    end
    chk({7'h0, n >= lo && n <= lo + 2}, 8'h01);
  endtask
  task t_mul;
    wr(8'hb9, 8'h00);
    wr(8'hb9, 8'h7c);
    rd(8'hb9, d);
    chk(d & 8'hbf, 8'h00);
    for (int s = 0; s < 3; s++) begin
      wr(8'hb9, s[7:0]);
      rd(8'hb9, d);
      chk(d, s[7:0]);
    end
    wr(8'hb9, 8'h82);
    n = 0;
    repeat (130) begin
      @(posedge clk);
      #1 n += mul_ref_clk_ff;
    end
    chk({7'h0, n >= 58 && n <= 72}, 8'h01);
    chk({7'h0, ext_osc_en_ff}, 8'h01);
    wr(8'hb9, 8'hc2);
    rd(8'hb9, d);
    chk(d & 8'hbf, 8'h82);
    n = 0;
    while (!d[5] && n < 300) begin
      rd(8'hb9, d);
      n++;
    end
    chk(d & 8'hbf, 8'ha2);
    if (n == 300) wrap_up();
    system_clock_signal_source_select = 2'h2;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      #1 n += system_clock_signal_mul_half_ff;
    end
    chk(n[7:0], 8'h04);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    t_regs();
    t_xtal();
    t_tick(8'h27, 19);
    t_tick(8'h37, 9);
    t_mul();
    wrap_up();
  end
endmodule // tb_eocm_top
bind eocm_top eocm_top_sva #(.SETTLE_CYC(SETTLE_CYC)) eocm_top_sva_inst (.clk, .reset_n, .ce,
  .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_ff, .ext_osc_en_ff, .ext_osc_mode_ff,
  .ext_freq_band_ff, .timer_tick_ff, .mul_enable_ff, .mul_init_pulse_ff, .mul_input_select_ff);
